// file: hw/chl_pkg.sv
// Shared constants and types for the charger limit register bank.
// Assumes a host-side serial engine that presents decoded register accesses.
package chl_pkg;

  // Register offsets
  localparam logic [7:0] CHL_OFS_BATV  = 8'h01;
  localparam logic [7:0] CHL_OFS_CHGI  = 8'h03;
  localparam logic [7:0] CHL_OFS_VFLR  = 8'h05;
  localparam logic [7:0] CHL_OFS_ICEIL = 8'h06;
  localparam logic [7:0] CHL_OFS_PRE   = 8'h08;

  // Field widths
  localparam int CHL_BATV_W  = 11;
  localparam int CHL_CHGI_W  = 9;
  localparam int CHL_VFLR_W  = 8;
  localparam int CHL_ICEIL_W = 9;
  localparam int CHL_PRE_W   = 8;

  // Step sizes and lower range limits in physical units
  localparam int CHL_BATV_STEP_MV  = 10;
  localparam int CHL_BATV_MIN_MV   = 3000;
  localparam int CHL_CHGI_STEP_MA  = 10;
  localparam int CHL_CHGI_MIN_MA   = 50;
  localparam int CHL_VFLR_STEP_MV  = 100;
  localparam int CHL_VFLR_MIN_MV   = 3600;
  localparam int CHL_ICEIL_STEP_MA = 10;
  localparam int CHL_ICEIL_MIN_MA  = 100;

  // Minimum codes derived from range and step
  localparam logic [CHL_BATV_W-1:0]  CHL_BATV_MIN  =
    CHL_BATV_W'(CHL_BATV_MIN_MV / CHL_BATV_STEP_MV);
  localparam logic [CHL_CHGI_W-1:0]  CHL_CHGI_MIN  =
    CHL_CHGI_W'(CHL_CHGI_MIN_MA / CHL_CHGI_STEP_MA);
  localparam logic [CHL_VFLR_W-1:0]  CHL_VFLR_MIN  =
    CHL_VFLR_W'(CHL_VFLR_MIN_MV / CHL_VFLR_STEP_MV);
  localparam logic [CHL_ICEIL_W-1:0] CHL_ICEIL_MIN =
    CHL_ICEIL_W'(CHL_ICEIL_MIN_MA / CHL_ICEIL_STEP_MA);

  // Charge voltage defaults per cell count (4.2 V, 8.4 V, 12.6 V, 16.8 V)
  localparam logic [CHL_BATV_W-1:0] CHL_BATV_1S = 11'h1A4;
  localparam logic [CHL_BATV_W-1:0] CHL_BATV_2S = 11'h348;
  localparam logic [CHL_BATV_W-1:0] CHL_BATV_3S = 11'h4EC;
  localparam logic [CHL_BATV_W-1:0] CHL_BATV_4S = 11'h690;

  // Reset values
  localparam logic [CHL_CHGI_W-1:0]  CHL_CHGI_RST  = 9'h064;
  localparam logic [CHL_VFLR_W-1:0]  CHL_VFLR_RST  = 8'h24;
  localparam logic [CHL_ICEIL_W-1:0] CHL_ICEIL_RST = 9'h12C;
  localparam logic [CHL_PRE_W-1:0]   CHL_PRE_RST   = 8'hC3;

  // Input current ceilings after port detection
  localparam logic [CHL_ICEIL_W-1:0] CHL_IC_SDP     = 9'h032;
  localparam logic [CHL_ICEIL_W-1:0] CHL_IC_CDP     = 9'h096;
  localparam logic [CHL_ICEIL_W-1:0] CHL_IC_DCP     = 9'h145;
  localparam logic [CHL_ICEIL_W-1:0] CHL_IC_HVCP    = 9'h096;
  localparam logic [CHL_ICEIL_W-1:0] CHL_IC_UNKNOWN = 9'h12C;
  localparam logic [CHL_ICEIL_W-1:0] CHL_IC_NS_1A   = 9'h064;
  localparam logic [CHL_ICEIL_W-1:0] CHL_IC_NS_2A   = 9'h0C8;
  localparam logic [CHL_ICEIL_W-1:0] CHL_IC_NS_21A  = 9'h0D2;
  localparam logic [CHL_ICEIL_W-1:0] CHL_IC_NS_24A  = 9'h0F0;

  // Detected input port kinds
  typedef enum logic [2:0] {
    CHL_PORT_SDP     = 3'b000,
    CHL_PORT_CDP     = 3'b001,
    CHL_PORT_DCP     = 3'b010,
    CHL_PORT_HVCP    = 3'b011,
    CHL_PORT_UNKNOWN = 3'b100,
    CHL_PORT_NONSTD  = 3'b101
  } chl_port_type;

  // Non-standard adapter current grades
  typedef enum logic [1:0] {
    CHL_NS_1A  = 2'b00,
    CHL_NS_2A  = 2'b01,
    CHL_NS_21A = 2'b10,
    CHL_NS_24A = 2'b11
  } chl_nonstd_type;

  // Host register access request
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } chl_req_type;

  // Port detection result
  typedef struct packed {
    logic           done;
    chl_port_type   port;
    chl_nonstd_type grade;
  } chl_detect_type;

  // Limit values handed to the regulation loops
  typedef struct packed {
    logic [CHL_BATV_W-1:0]  batt_v;
    logic [CHL_CHGI_W-1:0]  chg_i;
    logic [CHL_VFLR_W-1:0]  vin_floor;
    logic [CHL_ICEIL_W-1:0] iin_ceil;
    logic [CHL_PRE_W-1:0]   precharge;
  } chl_limits_type;

endpackage

// file: hw/chl_limit_regs.sv
// Charger limit register bank: charge voltage, charge current, input
// voltage floor, input current ceiling and precharge settings.
// Assumes all inputs are synchronous to REF_CLK and event inputs are
// single-cycle pulses; register accesses come from the serial front end.
`timescale 1ns/1ps

// Overview of operation
// - Charge voltage bits 10:0, 10 mV steps
// - Charge voltage default follows cell-count strap
// - Charge voltage restored by restore, not watchdog
// - Charge voltage writes below minimum ignored
// - Charge current bits 8:0, 10 mA, low-clamped
// - Charge current powers up at code 0x64
// - Charge current reset by watchdog and restore
// - Input floor bits 7:0, 100 mV, low-clamped
// - Adapter removal sets input floor 0x24
// - Adapter attach loads floor from bus measurement
// - Input floor ignores restore and watchdog
// - Input ceiling bits 8:0, 10 mA, low-clamped
// - Detection sets ceiling for SDP, CDP, DCP
// - Detection sets ceiling for HV, unknown, non-standard
// - Input ceiling powers up 0x12C, restore only
// - Below-minimum writes keep previous contents
// - Restore resets all registers except input floor, and charge timer
module chl_limit_regs
  import chl_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  RESET,
  input  wire logic [1:0]            CELL_COUNT_STRAP,
  input  wire logic                  REG_WR,
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic [15:0]           REG_WDATA,
  output logic      [15:0]           REG_RDATA,
  input  wire logic                  RESTORE_CMD,
  input  wire logic                  WDOG_EXPIRE,
  input  wire logic                  ADAPTER_REMOVED,
  input  wire logic                  ADAPTER_ATTACHED,
  input  wire logic [CHL_VFLR_W-1:0] VBUS_FLOOR_CODE,
  input  wire logic                  DETECT_DONE,
  input  wire logic [2:0]            DETECT_PORT,
  input  wire logic [1:0]            DETECT_GRADE,
  output logic                       STRAP_LOADED,
  output logic                       CHARGE_TIMER_RESET,
  output chl_limits_type             LIMITS
);

  // Register state and next values
  chl_req_type    req;
  chl_detect_type det;
  chl_limits_type lim_r;
  chl_limits_type lim_nxt;
  logic [CHL_BATV_W-1:0]  strap_batv_r;
  logic [CHL_BATV_W-1:0]  strap_batv_nxt;
  logic                   strap_done_r;
  logic                   strap_done_nxt;
  logic                   timer_rst_r;
  logic                   timer_rst_nxt;
  logic [15:0]            rdata_r;
  logic [15:0]            rdata_nxt;
  logic [CHL_BATV_W-1:0]  strap_dec;
  logic [CHL_ICEIL_W-1:0] detect_ceil;
  // Write strobes and clamp results
  logic                   hit_batv;
  logic                   hit_chgi;
  logic                   hit_vflr;
  logic                   hit_iceil;
  logic                   hit_pre;
  logic                   take_batv;
  logic                   take_chgi;
  logic                   take_vflr;
  logic                   take_iceil;

  assign req = '{wr: REG_WR, addr: REG_ADDR, wdata: REG_WDATA};
  assign det = '{done: DETECT_DONE, port: chl_port_type'(DETECT_PORT),
                 grade: chl_nonstd_type'(DETECT_GRADE)};

  // Write strobe per register offset
  assign hit_batv  = req.wr && (req.addr == CHL_OFS_BATV);
  assign hit_chgi  = req.wr && (req.addr == CHL_OFS_CHGI);
  assign hit_vflr  = req.wr && (req.addr == CHL_OFS_VFLR);
  assign hit_iceil = req.wr && (req.addr == CHL_OFS_ICEIL);
  assign hit_pre   = req.wr && (req.addr == CHL_OFS_PRE);

  // Low clamp: writes under the field minimum are dropped
  chl_clamp_field #(
    .W (CHL_BATV_W)
  ) u_clamp_batv (
    .wr_hit  (hit_batv),
    .value   (req.wdata[CHL_BATV_W-1:0]),
    .minimum (CHL_BATV_MIN),
    .take    (take_batv)
  );

  chl_clamp_field #(
    .W (CHL_CHGI_W)
  ) u_clamp_chgi (
    .wr_hit  (hit_chgi),
    .value   (req.wdata[CHL_CHGI_W-1:0]),
    .minimum (CHL_CHGI_MIN),
    .take    (take_chgi)
  );

  chl_clamp_field #(
    .W (CHL_VFLR_W)
  ) u_clamp_vflr (
    .wr_hit  (hit_vflr),
    .value   (req.wdata[CHL_VFLR_W-1:0]),
    .minimum (CHL_VFLR_MIN),
    .take    (take_vflr)
  );

  chl_clamp_field #(
    .W (CHL_ICEIL_W)
  ) u_clamp_iceil (
    .wr_hit  (hit_iceil),
    .value   (req.wdata[CHL_ICEIL_W-1:0]),
    .minimum (CHL_ICEIL_MIN),
    .take    (take_iceil)
  );

  // Cell count to charge voltage default
  always_comb
  begin
    unique case (CELL_COUNT_STRAP)
      2'b00: strap_dec = CHL_BATV_1S;
      2'b01: strap_dec = CHL_BATV_2S;
      2'b10: strap_dec = CHL_BATV_3S;
      2'b11: strap_dec = CHL_BATV_4S;
    endcase
  end

  // Detected port to input current ceiling
  always_comb
  begin
    unique case (det.port)
      CHL_PORT_SDP:     detect_ceil = CHL_IC_SDP;
      CHL_PORT_CDP:     detect_ceil = CHL_IC_CDP;
      CHL_PORT_DCP:     detect_ceil = CHL_IC_DCP;
      CHL_PORT_HVCP:    detect_ceil = CHL_IC_HVCP;
      CHL_PORT_UNKNOWN: detect_ceil = CHL_IC_UNKNOWN;
      CHL_PORT_NONSTD:
      begin
        unique case (det.grade)
          CHL_NS_1A:  detect_ceil = CHL_IC_NS_1A;
          CHL_NS_2A:  detect_ceil = CHL_IC_NS_2A;
          CHL_NS_21A: detect_ceil = CHL_IC_NS_21A;
          CHL_NS_24A: detect_ceil = CHL_IC_NS_24A;
        endcase
      end
      // Codes 6 and 7 read as an unknown adapter
      default:          detect_ceil = CHL_IC_UNKNOWN;
    endcase
  end

  // Limit fields; later events override earlier ones in one cycle
  always_comb
  begin
    lim_nxt = lim_r;

    // Host writes that passed the clamp, and unclamped precharge writes
    if (take_batv)
      lim_nxt.batt_v = req.wdata[CHL_BATV_W-1:0];
    if (take_chgi)
      lim_nxt.chg_i = req.wdata[CHL_CHGI_W-1:0];
    if (take_vflr)
      lim_nxt.vin_floor = req.wdata[CHL_VFLR_W-1:0];
    if (take_iceil)
      lim_nxt.iin_ceil = req.wdata[CHL_ICEIL_W-1:0];
    if (hit_pre)
      lim_nxt.precharge = req.wdata[CHL_PRE_W-1:0];

    // Input port events
    if (ADAPTER_ATTACHED)
      lim_nxt.vin_floor = VBUS_FLOOR_CODE;
    if (ADAPTER_REMOVED)
      lim_nxt.vin_floor = CHL_VFLR_RST;
    if (det.done)
      lim_nxt.iin_ceil = detect_ceil;

    // Watchdog touches only the charge current here
    if (WDOG_EXPIRE)
      lim_nxt.chg_i = CHL_CHGI_RST;

    // Restore command; input floor is left untouched
    if (RESTORE_CMD)
    begin
      lim_nxt.batt_v    = strap_batv_r;
      lim_nxt.chg_i     = CHL_CHGI_RST;
      lim_nxt.iin_ceil  = CHL_ICEIL_RST;
      lim_nxt.precharge = CHL_PRE_RST;
    end

    // Strap default wins in the first cycle after reset release
    if (!strap_done_r)
    begin
      lim_nxt.batt_v = strap_dec;
      lim_nxt.chg_i  = CHL_CHGI_RST;
    end
  end

  // One-cell default stands until the strap is sensed
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      lim_r <= '{batt_v: CHL_BATV_1S, chg_i: CHL_CHGI_RST,
                 vin_floor: CHL_VFLR_RST, iin_ceil: CHL_ICEIL_RST,
                 precharge: CHL_PRE_RST};
    else
      lim_r <= lim_nxt;
  end

  // Strap sensed once, cell-count default kept for restores
  always_comb
  begin
    strap_done_nxt = 1'b1;
    strap_batv_nxt = strap_batv_r;
    if (!strap_done_r)
      strap_batv_nxt = strap_dec;
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      strap_batv_r <= CHL_BATV_1S;
      strap_done_r <= 1'b0;
    end
    else
    begin
      strap_batv_r <= strap_batv_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  // Charge timer reset, one pulse per restore cycle
  always_comb
  begin
    timer_rst_nxt = RESTORE_CMD;
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      timer_rst_r <= 1'b0;
    else
      timer_rst_r <= timer_rst_nxt;
  end

  // Read data, reserved bits zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    unique case (req.addr)
      CHL_OFS_BATV:  rdata_nxt[CHL_BATV_W-1:0]  = lim_r.batt_v;
      CHL_OFS_CHGI:  rdata_nxt[CHL_CHGI_W-1:0]  = lim_r.chg_i;
      CHL_OFS_VFLR:  rdata_nxt[CHL_VFLR_W-1:0]  = lim_r.vin_floor;
      CHL_OFS_ICEIL: rdata_nxt[CHL_ICEIL_W-1:0] = lim_r.iin_ceil;
      CHL_OFS_PRE:   rdata_nxt[CHL_PRE_W-1:0]   = lim_r.precharge;
      default:       rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      rdata_r <= 16'h0000;
    else
      rdata_r <= rdata_nxt;
  end

  // Outputs straight from flip-flops
  assign LIMITS             = lim_r;
  assign REG_RDATA          = rdata_r;
  assign STRAP_LOADED       = strap_done_r;
  assign CHARGE_TIMER_RESET = timer_rst_r;

endmodule

// Low-clamp acceptance for one writable field
// Shared by four of the five limit fields; precharge writes are not clamped
module chl_clamp_field
  import chl_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         wr_hit,
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] minimum,
  output logic              take
);

  // The minimum itself is legal; only lower codes are dropped
  always_comb
  begin
    take = 1'b0;
    if (wr_hit && (value >= minimum))
      take = 1'b1;
  end

endmodule

// file: test/chl_limit_regs_assertions.sv
// Checker for the limit register bank, bound to its top module.
// Assumes the strap load lands at the first edge after reset release.
`timescale 1ns/1ps
module chl_limit_regs_assertions
  import chl_pkg::*;
(
  input wire logic           REF_CLK,
  input wire logic           RESET,
  input wire logic           REG_WR,
  input wire logic [7:0]     REG_ADDR,
  input wire logic [15:0]    REG_WDATA,
  input wire logic [15:0]    REG_RDATA,
  input wire logic           RESTORE_CMD,
  input wire logic           WDOG_EXPIRE,
  input wire logic           ADAPTER_REMOVED,
  input wire logic           ADAPTER_ATTACHED,
  input wire logic           STRAP_LOADED,
  input wire logic           CHARGE_TIMER_RESET,
  input wire chl_limits_type LIMITS
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  AST_TMR_PULSE: assert property (CHARGE_TIMER_RESET == $past(RESTORE_CMD))
    else $error("timer reset pulse wrong");
  AST_FAST_CHARGE_CURRENT_WDOG: assert property (WDOG_EXPIRE && STRAP_LOADED |=> LIMITS.chg_i == 9'h064)
    else $error("charge current not reset by watchdog");
  AST_BATT_WDOG: assert property (WDOG_EXPIRE && !RESTORE_CMD && !REG_WR && STRAP_LOADED
    |=> $stable(LIMITS.batt_v)) else $error("charge voltage moved on watchdog");
  AST_VFLR_KEEP: assert property ((RESTORE_CMD || WDOG_EXPIRE) && !REG_WR
    && !ADAPTER_REMOVED && !ADAPTER_ATTACHED |=> $stable(LIMITS.vin_floor))
    else $error("input floor moved on restore or watchdog");
  AST_REMOVE: assert property (ADAPTER_REMOVED |=> LIMITS.vin_floor == 8'h24)
    else $error("input floor not reset on removal");
  AST_ICEIL_RST: assert property (RESTORE_CMD |=> LIMITS.iin_ceil == 9'h12C)
    else $error("input ceiling not restored");
  AST_BATT_CLAMP: assert property (REG_WR && REG_ADDR == 8'h01 && !RESTORE_CMD
    && STRAP_LOADED && REG_WDATA[10:0] < 11'h12C |=> $stable(LIMITS.batt_v))
    else $error("low charge voltage write taken");
  AST_RSVD: assert property (REG_ADDR == 8'h01 |=> REG_RDATA[15:11] == 5'h00)
    else $error("reserved bits not zero");
  COV_RESTORE: cover property (RESTORE_CMD ##1 CHARGE_TIMER_RESET);
  COV_WDOG: cover property (WDOG_EXPIRE && STRAP_LOADED);
  COV_CLAMP: cover property (REG_WR && REG_ADDR == 8'h01 && REG_WDATA[10:0] < 11'h12C);
endmodule

bind chl_limit_regs chl_limit_regs_assertions u_chk (.REF_CLK(REF_CLK), .RESET(RESET),
  .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .RESTORE_CMD(RESTORE_CMD), .WDOG_EXPIRE(WDOG_EXPIRE), .ADAPTER_REMOVED(ADAPTER_REMOVED),
  .ADAPTER_ATTACHED(ADAPTER_ATTACHED), .STRAP_LOADED(STRAP_LOADED),
  .CHARGE_TIMER_RESET(CHARGE_TIMER_RESET), .LIMITS(LIMITS));

// file: test/chl_host_model.sv
// Host model driving the decoded register port.
// Assumes its tasks are called from one process only.
`timescale 1ns/1ps
module chl_host_model
(
  input  wire logic        REF_CLK,
  input  wire logic [15:0] REG_RDATA,
  output logic             REG_WR,
  output logic [7:0]       REG_ADDR,
  output logic [15:0]      REG_WDATA
);
  initial
  begin
    REG_WR    = 1'b0;
    REG_ADDR  = 8'h00;
    REG_WDATA = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge REF_CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge REF_CLK);
    REG_WR    <= 1'b0;
    // Released data shows the inverted word, not the last word
    REG_WDATA <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    @(posedge REF_CLK);
    #1 d = REG_RDATA;
  endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the limit register bank.
// Assumes the host model owns the register port; events come from here.
`timescale 1ns/1ps
module testbench
  import chl_pkg::*;
;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [1:0] strap = 2'h0;
  logic [4:0] ev = 5'h00;
  logic [7:0] vfc = 8'h00;
  logic [2:0] port = 3'h0;
  logic [1:0] grade = 2'h0;
  logic wr, stl, ctr;
  logic [7:0] addr;
  logic [15:0] wd, rdat, d;
  chl_limits_type lim;
  int n_fail = 0;
  int n_checks = 0;
  chl_host_model u_host (.REF_CLK(REF_CLK), .REG_RDATA(rdat), .REG_WR(wr), .REG_ADDR(addr),
    .REG_WDATA(wd));
  chl_limit_regs u_dut (.REF_CLK(REF_CLK), .RESET(RESET), .CELL_COUNT_STRAP(strap),
    .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdat), .RESTORE_CMD(ev[0]),
    .WDOG_EXPIRE(ev[1]), .ADAPTER_REMOVED(ev[2]), .ADAPTER_ATTACHED(ev[3]),
    .VBUS_FLOOR_CODE(vfc), .DETECT_DONE(ev[4]), .DETECT_PORT(port), .DETECT_GRADE(grade),
    .STRAP_LOADED(stl), .CHARGE_TIMER_RESET(ctr), .LIMITS(lim));
  initial
    forever #20 REF_CLK = ~REF_CLK;
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic rchk(input string s, input logic [7:0] a, input logic [15:0] e);
    u_host.rd(a, d);
    chk(s, d, e);
  endtask
  task automatic pulse(input int i);
    @(posedge REF_CLK);
    ev[i] <= 1'b1;
    @(posedge REF_CLK);
    ev <= 5'h00;
    #1;
  endtask
  task automatic t_por;
    logic [15:0] vd [4] = '{16'h01A4, 16'h0348, 16'h04EC, 16'h0690};
    for (int s = 0; s < 4; s++)
    begin
      if (s > 0)
        @(posedge REF_CLK);
      strap <= s[1:0];
      RESET <= 1'b1;
      repeat (6) @(posedge REF_CLK);
      chk("strap held", 16'(stl), 16'h0000);
      RESET <= 1'b0;
      repeat (2) @(posedge REF_CLK);
      rchk("batt_v", 8'h01, vd[s]);
      chk("strap loaded", 16'(stl), 16'h0001);
    end
    rchk("chg_i", 8'h03, 16'h0064);
    rchk("vin_floor", 8'h05, 16'h0024);
    rchk("iin_ceil", 8'h06, 16'h012C);
    rchk("precharge", 8'h08, 16'h00C3);
    rchk("unmapped", 8'h02, 16'h0000);
    $display("test por done");
  endtask
  task automatic t_clamp;
    logic [7:0] a [4] = '{8'h01, 8'h03, 8'h05, 8'h06};
    logic [15:0] mn [4] = '{16'h012C, 16'h0005, 16'h0024, 16'h000A};
    logic [15:0] mk [4] = '{16'h07FF, 16'h01FF, 16'h00FF, 16'h01FF};
    for (int i = 0; i < 4; i++)
    begin
      u_host.wr(a[i], mn[i]);
      rchk("at minimum", a[i], mn[i]);
      u_host.wr(a[i], mn[i] - 16'h0001);
      rchk("below minimum", a[i], mn[i]);
      u_host.wr(a[i], 16'hFFFF);
      rchk("field width", a[i], mk[i]);
    end
    $display("test clamp done");
  endtask
  task automatic t_events;
    u_host.wr(8'h08, 16'h0000);
    pulse(1);
    chk("wdog chg_i", 16'(lim.chg_i), 16'h0064);
    chk("wdog batt_v", 16'(lim.batt_v), 16'h07FF);
    chk("wdog iin_ceil", 16'(lim.iin_ceil), 16'h01FF);
    chk("wdog vin_floor", 16'(lim.vin_floor), 16'h00FF);
    u_host.wr(8'h03, 16'h00C8);
    pulse(0);
    chk("timer reset", 16'(ctr), 16'h0001);
    chk("rst batt_v", 16'(lim.batt_v), 16'h0690);
    chk("rst chg_i", 16'(lim.chg_i), 16'h0064);
    chk("rst iin_ceil", 16'(lim.iin_ceil), 16'h012C);
    chk("rst vin_floor", 16'(lim.vin_floor), 16'h00FF);
    chk("rst precharge", 16'(lim.precharge), 16'h00C3);
    @(posedge REF_CLK);
    #1 chk("timer reset end", 16'(ctr), 16'h0000);
    @(posedge REF_CLK);
    vfc <= 8'h50;
    pulse(3);
    chk("attach floor", 16'(lim.vin_floor), 16'h0050);
    pulse(2);
    chk("remove floor", 16'(lim.vin_floor), 16'h0024);
    $display("test events done");
  endtask
  task automatic t_detect;
    logic [15:0] ic [10] = '{16'h0032, 16'h0096, 16'h0145, 16'h0096, 16'h012C,
      16'h0064, 16'h00C8, 16'h00D2, 16'h00F0, 16'h012C};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge REF_CLK);
      port <= (i < 5) ? 3'(i) : ((i < 9) ? 3'h5 : 3'h6);
      grade <= (i < 5) ? 2'h0 : 2'(i - 5);
      pulse(4);
      chk("detect ceiling", 16'(lim.iin_ceil), ic[i]);
    end
    $display("test detect done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge REF_CLK);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    t_por();
    t_clamp();
    t_events();
    t_detect();
    print_verdict();
  end
endmodule
